// ### test/tsc_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker for the sync and map register slice
// ****************************************************************
module tsc_regs_props (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [2:0]  pprot,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sync starts
  input wire logic        ns_sync_start,
  input wire logic        s_sync_start,
  // lookup
  input wire logic        lk_valid,
  input wire logic        ctx_valid,
  input wire logic [1:0]  ctx_type,
  input wire logic        ctx_translate,
  input wire logic        ctx_fault,
  input wire logic        ctx_attr_ovr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // one wait state, then a single answer cycle
  property p_wait; $rose(psel && penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait)
    else $error("pready not in second access cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("pslverr without pready");
  // a start only comes from a write access
  property p_ns;
    ns_sync_start |-> psel && penable && pwrite && pready;
  endproperty
  a_ns: assert property (p_ns)
    else $error("ns start without a write");
  // secure copy only reachable by secure transactions
  property p_s; s_sync_start |-> !pprot[1] && !ns_sync_start; endproperty
  a_s: assert property (p_s)
    else $error("secure start from wrong state");
  property p_len; $rose(ns_sync_start) |=> !ns_sync_start;
  endproperty
  a_len: assert property (p_len)
    else $error("ns start pulse not one cycle");
  property p_lk; lk_valid |=> ctx_valid; endproperty
  a_lk: assert property (p_lk)
    else $error("no context after lookup");
  property p_fault; ctx_valid && ctx_type[1] |-> ctx_fault && !ctx_attr_ovr;
  endproperty
  a_fault: assert property (p_fault)
    else $error("type 1x not a fault");
  property p_xl; ctx_valid |-> ctx_translate == (ctx_type == 2'b00);
  endproperty
  a_xl: assert property (p_xl)
    else $error("translate flag wrong");
endmodule
bind tsc_regs tsc_regs_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pprot(pprot), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ns_sync_start(ns_sync_start),
  .s_sync_start(s_sync_start), .lk_valid(lk_valid),
  .ctx_valid(ctx_valid), .ctx_type(ctx_type),
  .ctx_translate(ctx_translate), .ctx_fault(ctx_fault),
  .ctx_attr_ovr(ctx_attr_ovr)
);
`default_nettype wire

// ### test/tsc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_regs_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0]  pprot = 0;
  logic        pready, pslverr, er, ns_st, s_st, cv, ct, cb, cf, co;
  logic        ns_pend = 0, s_pend = 0, ns_done = 0, s_done = 0;
  logic        lk_valid = 0;
  logic [7:0]  lk_group = 0, bank;
  logic [1:0]  ty;
  logic [3:0]  attr;
  int          n_errors = 0, num_checks = 0, ns_cnt = 0, s_cnt = 0;
  always #5 pclk = ~pclk;
  // start pulses counted where they are settled
  always @(negedge pclk) begin
    ns_cnt += (ns_st === 1'b1);
    s_cnt += (s_st === 1'b1);
  end
  tsc_regs #(.NUM_MAP(16), .LK_W(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ns_inv_pending(ns_pend), .s_inv_pending(s_pend),
    .ns_sync_start(ns_st), .s_sync_start(s_st),
    .ns_sync_done(ns_done), .s_sync_done(s_done),
    .lk_valid(lk_valid), .lk_group(lk_group), .ext_match_en(1'b0),
    .ctx_valid(cv), .ctx_type(ty), .ctx_translate(ct), .ctx_bypass(cb),
    .ctx_fault(cf), .ctx_bank(bank), .ctx_attr_ovr(co), .ctx_attr(attr));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [32:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer; pprot[1] low marks a secure access
  task automatic apb(input logic wr, sec, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ~sec, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic sec, input logic [11:0] a,
                      input logic [31:0] exp, input string nm);
    apb(1'b0, sec, a, 32'h0000_0000);
    chk(nm, {er, rd}, {1'b0, exp});
  endtask
  // completion pulse from the tlb side, pending work cleared in the same cycle
  task automatic done(input logic s);
    @(posedge pclk);
    {s_pend, ns_pend} <= 2'b00;
    {s_done, ns_done} <= {s, ~s};
    @(posedge pclk);
    {s_done, ns_done} <= 2'b00;
    repeat (2) @(posedge pclk);
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    logic [31:0] v;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(0, tsc_pkg::SYNC_STATE_NS_OFF, 0, "ns rst");
    rchk(1, tsc_pkg::SYNC_STATE_S_OFF, 0, "s rst");
    // non-secure sync while invalidates are outstanding
    ns_pend <= 1'b1;
    apb(1, 0, tsc_pkg::SYNC_TRIG_NS_OFF, 32'hdead_beef);
    chk("ns starts", ns_cnt, 1);
    rchk(0, tsc_pkg::SYNC_STATE_NS_OFF, 1, "ns busy");
    rchk(1, tsc_pkg::SYNC_STATE_NS_OFF, 0, "s bank");
    rchk(1, tsc_pkg::SYNC_STATE_ALIAS_OFF, 1, "alias");
    done(0);
    rchk(0, tsc_pkg::SYNC_STATE_NS_OFF, 0, "ns clr");
    $display("test ns sync done");
    // secure alias drives the non-secure engine
    apb(1, 1, tsc_pkg::SYNC_TRIG_ALIAS_OFF, 32'h0000_0000);
    chk("alias starts", {16'(s_cnt), 16'(ns_cnt)}, 32'h0000_0002);
    rchk(0, tsc_pkg::SYNC_STATE_NS_OFF, 1, "alias busy");
    done(0);
    s_pend <= 1'b1;
    apb(1, 1, tsc_pkg::SYNC_TRIG_S_OFF, 32'h0000_0000);
    chk("s starts", {16'(s_cnt), 16'(ns_cnt)}, 32'h0001_0002);
    rchk(1, tsc_pkg::SYNC_STATE_S_OFF, 1, "s busy");
    rchk(0, tsc_pkg::SYNC_STATE_NS_OFF, 0, "ns idle");
    done(1);
    rchk(1, tsc_pkg::SYNC_STATE_S_OFF, 0, "s clr");
    // status is read-only; refused addresses
    apb(1, 0, tsc_pkg::SYNC_STATE_NS_OFF, 32'hffff_ffff);
    rchk(0, tsc_pkg::SYNC_STATE_NS_OFF, 0, "ro");
    apb(0, 0, tsc_pkg::SYNC_STATE_S_OFF, 32'h0000_0000);
    chk("ns to s", er, 1);
    apb(0, 0, 12'h400, 32'h0000_0000);
    chk("unmapped", {er, rd}, 33'h1_0000_0000);
    $display("test sync regs done");
    // map entries: every type, override on and off
    for (int i = 0; i < 8; i++) begin
      v = {14'h0, 2'(i), 4'ha, 1'(i >> 2), 3'h0, 8'(8'h40 + i)};
      apb(1, 0, tsc_pkg::MAP_BASE_OFF + 12'(4 * i), v);
      rchk(0, tsc_pkg::MAP_BASE_OFF + 12'(4 * i), v, "map rw");
      @(posedge pclk);
      lk_valid <= 1'b1;
      lk_group <= 8'(i);
      @(posedge pclk);
      lk_valid <= 1'b0;
      @(negedge pclk);
      chk("ctx", {cv, ty, ct, cb, cf, attr}, {1'b1, 2'(i), i % 4 == 0,
          i % 4 == 1, i % 4 > 1,
          ((i > 3) && (i % 4 < 2)) ? 4'ha : 4'h0});
      chk("ovr", co, (i > 3) && (i % 4 < 2));
      if (i % 4 == 0) chk("bank", bank, 8'h40 + i);
    end
    apb(1, 0, tsc_pkg::MAP_BASE_OFF + 12'h040, 32'h1234_5678);
    rchk(0, tsc_pkg::MAP_BASE_OFF + 12'h040, 0, "raz");
    $display("test map done");
    finish_test();
  end
endmodule
`default_nettype wire

// ### verilog/tsc_map_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// map storage: one write port, two registered read ports
// ****************************************************************
module tsc_map_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  // bus read port
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata,
  // lookup read port
  input  wire logic [AW-1:0] laddr,
  output logic      [31:0]   ldata
);

  // contents after reset are undefined, so no reset on the array
  logic [31:0] mem [DEPTH];

  // write and registered reads
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
    ldata <= mem[laddr];
  end

endmodule
`default_nettype wire

// ### verilog/tsc_pkg.sv
package tsc_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [11:0] SYNC_STATE_NS_OFF    = 12'h0_074; // non-secure status
  localparam logic [11:0] SYNC_TRIG_NS_OFF     = 12'h0_070; // non-secure trigger
  localparam logic [11:0] SYNC_STATE_S_OFF     = 12'h0_174; // secure status
  localparam logic [11:0] SYNC_TRIG_S_OFF      = 12'h0_170; // secure trigger
  localparam logic [11:0] SYNC_STATE_ALIAS_OFF = 12'h0_274; // secure alias, ns
  localparam logic [11:0] SYNC_TRIG_ALIAS_OFF  = 12'h0_270; // secure alias, ns
  localparam logic [11:0] MAP_BASE_OFF         = 12'h8_00;  // map array base
  localparam logic [11:0] MAP_END_OFF          = 12'hC_00;  // 256 words max

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          BUSY_BIT       = 0;
  localparam logic        BUSY_RESET     = 1'b0;
  localparam int          TYPE_LSB       = 16;
  localparam int          OVERRIDE_MEMORY_ATTRIBUTES_LSB    = 12;
  localparam int          MT_OVR_BIT     = 11;
  localparam int          CBIDX_LSB      = 0;

  // ****************************************************************
  // context type encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    TSC_CTX_TRANSLATE = 2'b00,
    TSC_CTX_BYPASS    = 2'b01,
    TSC_CTX_FAULT     = 2'b10,
    TSC_CTX_RSVD      = 2'b11
  } tsc_ctx_e;

  // sync engine states
  typedef enum logic [1:0] {
    TSC_SYNC_IDLE = 2'b00,
    TSC_SYNC_WAIT = 2'b01,
    TSC_SYNC_DONE = 2'b10
  } tsc_sync_e;

endpackage

// ### verilog/tsc_regs.sv
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - status bit0 high while sync busy
// - busy bit clears on reset
// - status read-only, bits 31:1 zero
// - banked status plus secure alias of non-secure
// - bank chosen by transaction security state
// - trigger write syncs all earlier invalidates
// - sync covers requesting security state
// - each trigger copy covers its own state
// - secure alias write triggers non-secure sync
// - trigger write-only, data value ignored
// - map entry gives matching stream's context
// - fields interpreted by type bits 17:16
// - extended matching: map onto last 128
// - unimplemented entries read zero, ignore writes
// - map entries 32-bit read-write, no reset
// - type decode; 11 treated as fault
// - attribute override only when enable set
module tsc_regs #(
  parameter int NUM_MAP = 16,  // implemented map entries
  parameter int LK_W    = 8    // lookup group index width
) (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [2:0]  pprot,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // invalidate tracking: pending flag per state from the tlb
  input  wire logic        ns_inv_pending,
  input  wire logic        s_inv_pending,
  // sync request to the tlb, pulse per state
  output logic             ns_sync_start,
  output logic             s_sync_start,
  // tlb reports completion of the started sync, pulse per state
  input  wire logic        ns_sync_done,
  input  wire logic        s_sync_done,
  // stream lookup
  input  wire logic            lk_valid,
  input  wire logic [LK_W-1:0] lk_group,
  input  wire logic            ext_match_en,
  output logic                 ctx_valid,
  output logic      [1:0]      ctx_type,
  output logic                 ctx_translate,
  output logic                 ctx_bypass,
  output logic                 ctx_fault,
  output logic      [7:0]      ctx_bank,
  output logic                 ctx_attr_ovr,
  output logic      [3:0]      ctx_attr
);

  localparam int AW = (NUM_MAP > 1) ? $clog2(NUM_MAP) : 1;

  // elaboration checks on the parameters
  initial begin
    if (NUM_MAP < 1 || NUM_MAP > 256) begin
      $error("NUM_MAP must lie in 1..256");
    end
    if (LK_W < 8) begin
      $error("LK_W must be at least 8");
    end
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire logic        secure_acc = ~pprot[1];
  logic             wait_reg;   // high in the answer cycle
  wire logic        acc        = psel & penable;
  // writes land only at the edge that completes the transfer, so a
  // trigger fires once and memory is written once per transfer
  wire logic        wr_acc     = acc & wait_reg & pwrite & (pstrb != 4'h0);
  wire logic [11:0] word_addr  = {paddr[11:2], 2'b00};

  // banked addresses: secure copies and alias only reachable by secure
  wire logic hit_st_ns  = word_addr == tsc_pkg::SYNC_STATE_NS_OFF;
  wire logic hit_tr_ns  = word_addr == tsc_pkg::SYNC_TRIG_NS_OFF;
  wire logic hit_st_s   = secure_acc & (word_addr == tsc_pkg::SYNC_STATE_S_OFF);
  wire logic hit_tr_s   = secure_acc & (word_addr == tsc_pkg::SYNC_TRIG_S_OFF);
  wire logic hit_st_al  = secure_acc &
                          (word_addr == tsc_pkg::SYNC_STATE_ALIAS_OFF);
  wire logic hit_tr_al  = secure_acc &
                          (word_addr == tsc_pkg::SYNC_TRIG_ALIAS_OFF);

  // map window; entries past NUM_MAP are RAZ/WI
  wire logic       in_map  = (word_addr >= tsc_pkg::MAP_BASE_OFF) &&
                             (word_addr <  tsc_pkg::MAP_END_OFF);
  wire logic [7:0] map_idx = paddr[9:2];
  wire logic       map_imp = in_map && (32'(map_idx) < NUM_MAP);
  wire logic [AW-1:0] map_a = map_idx[AW-1:0];

  // the non-secure state reaches its own copy; the secure state sees its
  // own at the shared address as well, giving a true banked layout
  wire logic st_ns_sel = (hit_st_ns & ~secure_acc) | hit_st_al;
  wire logic st_s_sel  = hit_st_s | (hit_st_ns & secure_acc);
  wire logic tr_ns_sel = (hit_tr_ns & ~secure_acc) | hit_tr_al;
  wire logic tr_s_sel  = hit_tr_s | (hit_tr_ns & secure_acc);

  // trigger fires on any write with a strobe set, value ignored
  wire logic ns_trig = wr_acc & tr_ns_sel;
  wire logic s_trig  = wr_acc & tr_s_sel;

  wire logic mapped  = st_ns_sel | st_s_sel | tr_ns_sel | tr_s_sel |
                       in_map;

  // ****************************************************************
  // sync engine, one per security state
  // ****************************************************************
  logic [1:0] busy_bits;
  logic [1:0] start_bits;
  wire  logic [1:0] trig_bits = {s_trig, ns_trig};
  wire  logic [1:0] done_bits = {s_sync_done, ns_sync_done};
  wire  logic [1:0] pend_bits = {s_inv_pending, ns_inv_pending};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      tsc_pkg::tsc_sync_e st_reg;
      tsc_pkg::tsc_sync_e st_next;

      // a trigger during a sync re-arms it so later invalidates are covered
      always_comb begin
        st_next = st_reg;
        case (st_reg)
          tsc_pkg::TSC_SYNC_IDLE: begin
            if (trig_bits[g]) begin
              st_next = tsc_pkg::TSC_SYNC_WAIT;
            end
          end
          tsc_pkg::TSC_SYNC_WAIT: begin
            // done from the tlb only counts once nothing earlier pends
            if (done_bits[g] && !pend_bits[g] && !trig_bits[g]) begin
              st_next = tsc_pkg::TSC_SYNC_IDLE;
            end
          end
          default: begin
            st_next = tsc_pkg::TSC_SYNC_IDLE;
          end
        endcase
      end

      // state register
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_reg <= tsc_pkg::TSC_SYNC_IDLE;
        end else begin
          st_reg <= st_next;
        end
      end

      // busy bit and start pulse for this state only
      assign busy_bits[g]  = st_reg == tsc_pkg::TSC_SYNC_WAIT;
      assign start_bits[g] = trig_bits[g];
    end
  endgenerate

  assign ns_sync_start = start_bits[0];
  assign s_sync_start  = start_bits[1];

  // ****************************************************************
  // map storage
  // ****************************************************************
  logic [31:0] map_rdata;
  logic [31:0] map_ldata;
  wire  logic  map_we = wr_acc & map_imp;

  // extended matching offsets the array: entry e answers group e + NUM_MAP - 128
  wire logic [LK_W-1:0] lk_base = ext_match_en ?
                                  LK_W'(NUM_MAP - 128) : '0;
  wire logic [LK_W-1:0] lk_off  = lk_group - lk_base;
  wire logic [AW-1:0]   lk_a    = lk_off[AW-1:0];
  wire logic            lk_hit  = 32'(lk_off) < NUM_MAP;

  tsc_map_mem #(
    .DEPTH (NUM_MAP),
    .AW    (AW)
  ) u_mem (
    .clk   (pclk),
    .we    (map_we),
    .waddr (map_a),
    .wdata (pwdata),
    .raddr (map_a),
    .rdata (map_rdata),
    .laddr (lk_a),
    .ldata (map_ldata)
  );

  // ****************************************************************
  // apb response: one wait state so the registered memory read lands
  // ****************************************************************
  logic        rd_map_reg;
  logic [31:0] rd_reg;

  // read mux for the non-memory registers, reserved bits zero
  wire logic [31:0] rd_sync =
      st_ns_sel ? {31'h0, busy_bits[0]} :
      st_s_sel  ? {31'h0, busy_bits[1]} : 32'h0000_0000;

  // wait-state toggle and captured read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg   <= 1'b0;
      rd_map_reg <= 1'b0;
      rd_reg     <= 32'h0000_0000;
    end else begin
      wait_reg   <= acc & ~wait_reg;
      rd_map_reg <= map_imp;
      rd_reg     <= rd_sync;
    end
  end

  assign pready  = wait_reg;
  assign pslverr = wait_reg & ~mapped;
  // unimplemented entries and unmapped words read as zero
  assign prdata  = !wait_reg ? 32'h0000_0000 :
                   rd_map_reg ? map_rdata : rd_reg;

  // ****************************************************************
  // context lookup, answered one cycle after the request
  // ****************************************************************
  logic lk_v_reg;
  logic lk_hit_reg;

  // lookup valid pipeline follows the memory read latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_v_reg   <= 1'b0;
      lk_hit_reg <= 1'b0;
    end else begin
      lk_v_reg   <= lk_valid;
      lk_hit_reg <= lk_hit;
    end
  end

  // a missing entry reads as zero, which selects translate bank 0
  wire logic [31:0] ent   = lk_hit_reg ? map_ldata : 32'h0000_0000;
  wire logic [1:0]  etype = ent[tsc_pkg::TYPE_LSB +: 2];

  assign ctx_valid     = lk_v_reg;
  assign ctx_type      = etype;
  assign ctx_translate = etype == tsc_pkg::TSC_CTX_TRANSLATE;
  assign ctx_bypass    = etype == tsc_pkg::TSC_CTX_BYPASS;
  // reserved type is handled as a fault context
  assign ctx_fault     = etype[1];
  assign ctx_bank      = ctx_translate ?
                         ent[tsc_pkg::CBIDX_LSB +: 8] : 8'h00;
  // attributes only count for translate and bypass with the override enabled;
  // software is expected to keep hints sane for device memory
  assign ctx_attr_ovr  = ~etype[1] & ent[tsc_pkg::MT_OVR_BIT];
  assign ctx_attr      = ctx_attr_ovr ?
                         ent[tsc_pkg::OVERRIDE_MEMORY_ATTRIBUTES_LSB +: 4] : 4'h0;

endmodule
`default_nettype wire
